/* rtl/rx_assess_regs.vh */
// register offsets, field positions, reset values and timing constants of the receive assessment block
`ifndef RX_ASSESS_REGS_VH
`define RX_ASSESS_REGS_VH
`define OFF_CCA_THRESHOLD_LEVEL   8'h13
`define OFF_CCA_CONTROL           8'h15
`define OFF_CCA_PROGRESS_LOW      8'h19
`define OFF_CCA_PROGRESS_HIGH     8'h1a
`define OFF_ENERGY_DETECT_CONTROL 8'h1b
`define OFF_RECEIVE_START_ADJUST  8'h22
`define OFF_INT_GROUP_ONE         8'h24
`define OFF_INT_GROUP_TWO         8'h25
`define OFF_INT_GROUP_THREE       8'h26
`define OFF_PACKET_MODE_SETTING   8'h45
`define OFF_ADDRESS_FILTER_CTRL   8'h60
`define OFF_DIVERSITY_SEARCH_TMR  8'h6f
`define OFF_DIVERSITY_CONTROL     8'h71
`define OFF_DIVERSITY_ENERGY      8'h72
`define OFF_DIVERSITY_ANTENNA     8'h73
`define OFF_RX_BUFFER_READ        8'h7f
// cca_control fields
`define BIT_AUTO_ENABLE  7
`define BIT_ASSESS_EN    4
`define BIT_LOOP_START   3
`define BIT_DONE_FLAG    2
`define BIT_ASSESS_STOP  5
// energy_detect_control
`define BIT_ENERGY_CALC  7
// interrupt groups
`define BIT_BANK1_CLEAR  7
`define BIT_BANK0_CLEAR  6
`define BIT_RX_DONE0     2
`define BIT_RX_DONE1     3
`define BIT_DIV_DONE     0
`define BIT_ASSESS_IRQ   1
// packet mode / diversity
`define BIT_FILTER_IDLE  0
`define BIT_STD_SELECT   1
`define BIT_DIV_ENABLE   1
// reset values
`define RST_BYTE         8'h00
`define RST_THRESHOLD    8'h50
`define RST_SEARCH_TMR   8'h10
// timing
`define CLK_MHZ          100
`define SETTLE_MIN_US    16
// 16 us at 100 MHz
`define SETTLE_CYCLES    12'd1600
`define ED_PERIOD_CYCLES 800
`define SEARCH_UNIT_CYC  100
`endif

/* rtl/rx_assess_ctrl.v */
// receive-side assessment, energy detect, diversity and receive buffer control
//
// Overview of operation
// (RL1) host reads one dummy byte in legacy mode
// (RL2) host clears buffer bank via group one
// (RL3) host clears receive interrupts in group three
// (RL4) physical-layer reset empties receive buffer
// (RL5) receive with calc enable starts energy detection
// (RL6) enable without loop runs single assessment
// (RL7) outcome compares energy against threshold register
// (RL8) single assessment self-clears enable, stays receiving
// (RL9) enable during receive adds settling wait
// (RL10) enable before receive adds no wait
// (RL11) synchronisation during assessment keeps current bandwidth
// (RL12) assessment during diversity restarts diversity search
// (RL13) loop start repeats assessment per energy value
// (RL14) continuous mode sets no done, no interrupt
// (RL15) continuous updates result/progress; stop freezes them
// (RL16) auto enable repeats assessment until idle
// (RL17) filter idle-detect assesses after filtered packet
// (RL18) diversity alternates antennas, picks higher energy
// (RL19) search timer expiry without preamble re-searches
// (RL20) interrupt clears wipe diversity energy and antenna
// (RL21) diversity enabled while receiving waits timer first
// (RL22) host keeps oscillator until sleep settles
`include "rx_assess_regs.vh"
module rx_assess_ctrl #(
  parameter DEPTH_LOG2 = 8,
  parameter ED_PERIOD  = `ED_PERIOD_CYCLES
) (
  // clock and reset
  input  wire       ref_clk_in,
  input  wire       rst_n_in,
  // register port from host interface
  input  wire       reg_wr_in,
  input  wire       reg_rd_in,
  input  wire [7:0] reg_addr_in,
  input  wire [7:0] reg_wdata_in,
  output reg  [7:0] reg_rdata_out,
  output reg        reg_rvalid_out,
  // radio state commands
  input  wire       rx_on_cmd_in,
  input  wire       transceiver_off_command_cmd_in,
  input  wire       phy_reset_in,
  // demodulator side
  input  wire [7:0] energy_sample_in,
  input  wire       preamble_det_in,
  input  wire       sfd_det_in,
  input  wire       filtered_drop_in,
  input  wire       rx_data_valid_in,
  input  wire [7:0] rx_data_in,
  output reg        rx_data_ready_out,
  output reg        rx_bank_done_out,
  // status
  output reg        receiving_out,
  output reg        antenna_sel_out,
  output reg        bandwidth_hold_out,
  output reg        assess_irq_out
);
////////////////////////////////////////////////////////////////////////
// synchronisers for the asynchronous preamble and SFD detect inputs
reg [2:0] pre_sync_q;
reg [2:0] sfd_sync_q;
always @(posedge ref_clk_in) begin
  if (!rst_n_in) begin
    pre_sync_q <= 3'h0;
    sfd_sync_q <= 3'h0;
  end else begin
    pre_sync_q <= {pre_sync_q[1:0], preamble_det_in};
    sfd_sync_q <= {sfd_sync_q[1:0], sfd_det_in};
  end
end
reg pre_q;
reg sfd_q;
always @(posedge ref_clk_in) begin
  if (!rst_n_in) begin
    pre_q <= 1'b0;
    sfd_q <= 1'b0;
  end else begin
    if (pre_sync_q[2] == pre_sync_q[1])
      pre_q <= pre_sync_q[2];
    if (sfd_sync_q[2] == sfd_sync_q[1])
      sfd_q <= sfd_sync_q[2];
  end
end
wire sfd_rise = sfd_sync_q[2] & sfd_sync_q[1] & ~sfd_q;
////////////////////////////////////////////////////////////////////////
// registers
reg [7:0] threshold_q;
reg       auto_en_q;
reg       assess_en_q;
reg       loop_start_q;
reg       stop_q;
reg       done_q;
reg [1:0] result_q;
reg [15:0] progress_q;
reg       calc_en_q;
reg [7:0] energy_q;
reg [7:0] rx_adjust_q;
reg [7:0] grp1_q;
reg [7:0] grp2_q;
reg [7:0] grp3_q;
reg [7:0] pkt_mode_q;
reg [7:0] filter_ctrl_q;
reg [7:0] search_tmr_q;
reg [7:0] div_ctrl_q;
reg [7:0] div_energy_q;
reg       div_ant_q;
reg       receiving_q;
wire wr_grp1 = reg_wr_in && reg_addr_in == `OFF_INT_GROUP_ONE;
wire wr_grp3 = reg_wr_in && reg_addr_in == `OFF_INT_GROUP_THREE;
wire wr_cca  = reg_wr_in && reg_addr_in == `OFF_CCA_CONTROL;
wire wr_div  = reg_wr_in && reg_addr_in == `OFF_DIVERSITY_CONTROL;
////////////////////////////////////////////////////////////////////////
// two-entry receive buffer in front of the drain port
reg [7:0]           buf_q [0:1];
reg                 wp_q;
reg                 rp_q;
reg [1:0]           cnt_q;
wire buf_full  = cnt_q == 2'd2;
wire buf_empty = cnt_q == 2'd0;
wire rd_fifo   = reg_rd_in && reg_addr_in == `OFF_RX_BUFFER_READ;
wire push      = rx_data_valid_in && rx_data_ready_out && !buf_full && receiving_q;
wire pop       = rd_fifo && !buf_empty;
wire bank_clr  = wr_grp1 && (!reg_wdata_in[`BIT_BANK1_CLEAR] || !reg_wdata_in[`BIT_BANK0_CLEAR]); // RL2
always @(posedge ref_clk_in) begin
  if (!rst_n_in || phy_reset_in || bank_clr) begin // RL4
    wp_q  <= 1'b0;
    rp_q  <= 1'b0;
    cnt_q <= 2'd0;
  end else begin
    if (push) begin
      buf_q[wp_q] <= rx_data_in;
      wp_q        <= ~wp_q;
    end
    if (pop)
      rp_q <= ~rp_q;
    cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
  end
end
////////////////////////////////////////////////////////////////////////
// energy measurement period
reg [9:0] ed_cnt_q;
reg       ed_tick_q;
reg       ed_seen_q; // energy_q holds the fresh value one cycle after the tick
always @(posedge ref_clk_in) begin
  if (!rst_n_in || !receiving_q) begin
    ed_cnt_q  <= 10'd0;
    ed_tick_q <= 1'b0;
    ed_seen_q <= 1'b0;
  end else begin
    ed_seen_q <= ed_tick_q;
    ed_tick_q <= ed_cnt_q == ED_PERIOD[9:0] - 10'd1;
    ed_cnt_q  <= (ed_cnt_q == ED_PERIOD[9:0] - 10'd1) ? 10'd0 : ed_cnt_q + 10'd1;
  end
end
////////////////////////////////////////////////////////////////////////
// assessment sequencer
localparam S_IDLE = 2'd0;
localparam S_WAIT = 2'd1;
localparam S_RUN  = 2'd2;
reg [1:0]  st_q;
reg [11:0] settle_q;
wire       busy_chan = energy_q >= threshold_q; // RL7
wire       idle_mode = auto_en_q; // RL16
wire       filt_idle = |filter_ctrl_q[4:0] && pkt_mode_q[`BIT_FILTER_IDLE]; // RL17
always @(posedge ref_clk_in) begin
  if (!rst_n_in) begin
    st_q         <= S_IDLE;
    settle_q     <= 12'd0;
    assess_en_q  <= 1'b0;
    loop_start_q <= 1'b0;
    stop_q       <= 1'b0;
    auto_en_q    <= 1'b0;
    done_q       <= 1'b0;
    result_q     <= 2'd0;
    progress_q   <= 16'h0000;
    bandwidth_hold_out <= 1'b0;
  end else begin
    if (wr_cca) begin
      auto_en_q    <= reg_wdata_in[`BIT_AUTO_ENABLE];
      assess_en_q  <= reg_wdata_in[`BIT_ASSESS_EN];
      loop_start_q <= reg_wdata_in[`BIT_LOOP_START];
      stop_q       <= reg_wdata_in[`BIT_ASSESS_STOP];
      if (!reg_wdata_in[`BIT_DONE_FLAG])
        done_q <= 1'b0;
    end
    if (filtered_drop_in && filt_idle)
      assess_en_q <= 1'b1; // RL17
    case (st_q)
      S_IDLE: begin
        if (rx_on_cmd_in && assess_en_q) begin
          st_q <= S_RUN; // RL6 RL10
        end else if (wr_cca && receiving_q && reg_wdata_in[`BIT_ASSESS_EN]) begin
          st_q     <= S_WAIT; // RL9
          settle_q <= `SETTLE_CYCLES;
        end else if (receiving_q && filtered_drop_in && filt_idle) begin
          st_q <= S_RUN;
        end
      end
      S_WAIT: begin
        if (settle_q == 12'd1)
          st_q <= S_RUN;
        settle_q <= settle_q - 12'd1;
      end
      S_RUN: begin
        if (sfd_rise)
          bandwidth_hold_out <= 1'b1; // RL11
        if (ed_seen_q && !stop_q) begin // RL15
          result_q   <= busy_chan ? 2'd1 : 2'd0;
          progress_q <= progress_q + 16'h0001;
          if (loop_start_q) begin
            st_q <= S_RUN; // RL13 RL14
          end else if ((idle_mode || filt_idle) && busy_chan) begin
            st_q <= S_RUN; // RL16
          end else begin
            st_q        <= S_IDLE;
            assess_en_q <= 1'b0; // RL8
            done_q      <= 1'b1;
          end
        end
        if (!receiving_q)
          st_q <= S_IDLE;
      end
      default: st_q <= S_IDLE;
    endcase
  end
end
wire assess_fin = st_q == S_RUN && ed_seen_q && !stop_q && !loop_start_q &&
                  !((idle_mode || filt_idle) && busy_chan);
////////////////////////////////////////////////////////////////////////
// receive state and energy detection
always @(posedge ref_clk_in) begin
  if (!rst_n_in || transceiver_off_command_cmd_in || phy_reset_in)
    receiving_q <= 1'b0;
  else if (rx_on_cmd_in)
    receiving_q <= 1'b1;
end
always @(posedge ref_clk_in) begin
  if (!rst_n_in)
    energy_q <= `RST_BYTE;
  else if (receiving_q && (calc_en_q || st_q == S_RUN) && ed_tick_q)
    energy_q <= energy_sample_in; // RL5
end
////////////////////////////////////////////////////////////////////////
// diversity search
localparam D_OFF    = 2'd0;
localparam D_MEAS   = 2'd1;
localparam D_TIMER  = 2'd2;
localparam D_HOLD   = 2'd3;
reg [1:0]  dst_q;
reg [15:0] dtmr_q;
reg        branch_q;
reg [7:0]  e0_q;
reg        div_done_set;
wire       div_wipe = (wr_grp3 && !reg_wdata_in[`BIT_DIV_DONE]) ||
                      (wr_grp3 && dst_q == D_MEAS &&
                       (!reg_wdata_in[`BIT_RX_DONE0] || !reg_wdata_in[`BIT_RX_DONE1])); // RL20
always @(posedge ref_clk_in) begin
  div_done_set <= 1'b0;
  if (!rst_n_in || !receiving_q || !div_ctrl_q[`BIT_DIV_ENABLE]) begin
    dst_q     <= D_OFF;
    dtmr_q    <= 16'h0000;
    branch_q  <= 1'b0;
    e0_q      <= `RST_BYTE;
    div_energy_q <= `RST_BYTE;
    div_ant_q <= 1'b0;
    div_done_set <= 1'b0;
  end else begin
    if (div_wipe) begin
      div_energy_q <= `RST_BYTE;
      div_ant_q    <= 1'b0;
    end
    case (dst_q)
      D_OFF: begin
        if (!receiving_out) begin
          dst_q <= D_MEAS; // RL18
        end else begin
          dst_q  <= D_TIMER; // RL21
          dtmr_q <= {search_tmr_q, 8'h00};
        end
      end
      D_MEAS: begin
        if (assess_fin)
          branch_q <= 1'b0; // RL12
        else if (ed_tick_q && pre_q) begin
          if (!branch_q) begin
            e0_q     <= energy_sample_in;
            branch_q <= 1'b1;
          end else begin
            div_ant_q    <= energy_sample_in > e0_q; // RL18
            div_energy_q <= (energy_sample_in > e0_q) ? energy_sample_in : e0_q;
            branch_q     <= 1'b0;
            div_done_set <= 1'b1;
            dst_q        <= D_TIMER;
            dtmr_q       <= {search_tmr_q, 8'h00};
          end
        end
      end
      D_TIMER: begin
        if (sfd_rise) begin
          dst_q <= D_HOLD; // RL21
        end else if (dtmr_q == 16'h0000) begin
          dst_q <= pre_q ? D_HOLD : D_MEAS; // RL19
        end else begin
          dtmr_q <= dtmr_q - 16'h0001;
        end
      end
      D_HOLD: begin
        if (wr_grp3 && !reg_wdata_in[`BIT_DIV_DONE])
          dst_q <= D_MEAS;
      end
      default: dst_q <= D_OFF;
    endcase
  end
end
////////////////////////////////////////////////////////////////////////
// plain control registers and interrupt sources
always @(posedge ref_clk_in) begin
  if (!rst_n_in) begin
    threshold_q   <= `RST_THRESHOLD;
    calc_en_q     <= 1'b0;
    rx_adjust_q   <= `RST_BYTE;
    grp1_q        <= `RST_BYTE;
    grp2_q        <= `RST_BYTE;
    grp3_q        <= `RST_BYTE;
    pkt_mode_q    <= `RST_BYTE;
    filter_ctrl_q <= `RST_BYTE;
    search_tmr_q  <= `RST_SEARCH_TMR;
    div_ctrl_q    <= `RST_BYTE;
  end else begin
    if (reg_wr_in) begin
      case (reg_addr_in)
        `OFF_CCA_THRESHOLD_LEVEL:   threshold_q   <= reg_wdata_in;
        `OFF_ENERGY_DETECT_CONTROL: calc_en_q     <= reg_wdata_in[`BIT_ENERGY_CALC];
        `OFF_RECEIVE_START_ADJUST:  rx_adjust_q   <= reg_wdata_in;
        `OFF_INT_GROUP_ONE:         grp1_q        <= grp1_q & reg_wdata_in;
        `OFF_INT_GROUP_TWO:         grp2_q        <= grp2_q & reg_wdata_in;
        `OFF_INT_GROUP_THREE:       grp3_q        <= grp3_q & reg_wdata_in; // RL3
        `OFF_PACKET_MODE_SETTING:   pkt_mode_q    <= reg_wdata_in;
        `OFF_ADDRESS_FILTER_CTRL:   filter_ctrl_q <= reg_wdata_in;
        `OFF_DIVERSITY_SEARCH_TMR:  search_tmr_q  <= reg_wdata_in;
        `OFF_DIVERSITY_CONTROL:     div_ctrl_q    <= reg_wdata_in;
        default: ;
      endcase
    end
    // set wins over a simultaneous clear
    if (div_done_set)
      grp3_q[`BIT_DIV_DONE] <= 1'b1;
    if (assess_fin)
      grp3_q[`BIT_ASSESS_IRQ] <= 1'b1; // RL14
  end
end
////////////////////////////////////////////////////////////////////////
// read port and outputs
always @(posedge ref_clk_in) begin
  if (!rst_n_in) begin
    reg_rdata_out      <= 8'h00;
    reg_rvalid_out     <= 1'b0;
    rx_data_ready_out  <= 1'b0;
    rx_bank_done_out   <= 1'b0;
    receiving_out      <= 1'b0;
    antenna_sel_out    <= 1'b0;
    assess_irq_out     <= 1'b0;
  end else begin
    reg_rvalid_out    <= reg_rd_in;
    rx_data_ready_out <= !buf_full && !push && receiving_q;
    rx_bank_done_out  <= buf_empty && !push;
    receiving_out     <= receiving_q;
    antenna_sel_out   <= (dst_q == D_MEAS) ? branch_q : div_ant_q;
    assess_irq_out    <= grp3_q[`BIT_ASSESS_IRQ];
    case (reg_addr_in)
      `OFF_CCA_THRESHOLD_LEVEL:   reg_rdata_out <= threshold_q;
      `OFF_CCA_CONTROL:           reg_rdata_out <= {auto_en_q, 1'b0, stop_q, assess_en_q, loop_start_q,
                                                    done_q, result_q};
      `OFF_CCA_PROGRESS_LOW:      reg_rdata_out <= progress_q[7:0];
      `OFF_CCA_PROGRESS_HIGH:     reg_rdata_out <= progress_q[15:8];
      `OFF_ENERGY_DETECT_CONTROL: reg_rdata_out <= {calc_en_q, 7'h00};
      `OFF_RECEIVE_START_ADJUST:  reg_rdata_out <= rx_adjust_q;
      `OFF_INT_GROUP_ONE:         reg_rdata_out <= grp1_q;
      `OFF_INT_GROUP_TWO:         reg_rdata_out <= grp2_q;
      `OFF_INT_GROUP_THREE:       reg_rdata_out <= grp3_q;
      `OFF_PACKET_MODE_SETTING:   reg_rdata_out <= pkt_mode_q;
      `OFF_ADDRESS_FILTER_CTRL:   reg_rdata_out <= filter_ctrl_q;
      `OFF_DIVERSITY_SEARCH_TMR:  reg_rdata_out <= search_tmr_q;
      `OFF_DIVERSITY_CONTROL:     reg_rdata_out <= div_ctrl_q;
      `OFF_DIVERSITY_ENERGY:      reg_rdata_out <= div_energy_q;
      `OFF_DIVERSITY_ANTENNA:     reg_rdata_out <= {7'h00, div_ant_q};
      `OFF_RX_BUFFER_READ:        reg_rdata_out <= buf_empty ? 8'h00 : buf_q[rp_q];
      default:                    reg_rdata_out <= 8'h00;
    endcase
  end
end
endmodule

/* tb/rx_assess_monitor.sv */
// port-level assertions and covers for the receive assessment block
module rx_assess_monitor #(
  parameter DEPTH_LOG2 = 8,
  parameter ED_PERIOD  = 800
) (
  // clock and reset
  input wire       ref_clk_in,
  input wire       rst_n_in,
  // register port
  input wire       reg_wr_in,
  input wire       reg_rd_in,
  input wire [7:0] reg_addr_in,
  input wire [7:0] reg_wdata_in,
  input wire [7:0] reg_rdata_out,
  input wire       reg_rvalid_out,
  // radio commands
  input wire       rx_on_cmd_in,
  input wire       transceiver_off_command_cmd_in,
  input wire       phy_reset_in,
  // status
  input wire       rx_data_ready_out,
  input wire       rx_bank_done_out,
  input wire       receiving_out,
  input wire       antenna_sel_out,
  input wire       assess_irq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking mon_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////
  a_read_answered: assert property (reg_rd_in |=> reg_rvalid_out)
    else $error("read strobe not answered next cycle");
  a_answer_has_cause: assert property (reg_rvalid_out |-> $past(reg_rd_in))
    else $error("read answer without a read");
  a_unmapped_reads_zero: assert property ((reg_rd_in && reg_addr_in == 8'h30) |=> reg_rdata_out == 8'h00)
    else $error("unmapped read not zero");
  a_threshold_read_back: assert property ((reg_wr_in && reg_addr_in == 8'h13) ##2
    (reg_rd_in && reg_addr_in == 8'h13) |=> reg_rdata_out == $past(reg_wdata_in, 3))
    else $error("threshold does not read back");
  a_bank_clear_empties: assert property ((reg_wr_in && reg_addr_in == 8'h24 && reg_wdata_in[7:6] != 2'b11)
    |-> ##[1:2] rx_bank_done_out)
    else $error("bank clear did not empty buffer");
  a_phy_reset_empties: assert property (phy_reset_in |-> ##[1:2] rx_bank_done_out)
    else $error("phy reset did not empty buffer");
  a_rx_on_receives: assert property (rx_on_cmd_in |-> ##[1:2] receiving_out)
    else $error("receive command not followed");
  a_off_stops_rx: assert property (transceiver_off_command_cmd_in |-> ##[1:2] !receiving_out)
    else $error("off command not followed");
  a_done_in_receive: assert property ($rose(assess_irq_out) |-> receiving_out)
    else $error("assessment finished outside receive");
  a_irq_holds_high: assert property ((assess_irq_out && !(reg_wr_in && reg_addr_in == 8'h26)
    && !$past(reg_wr_in && reg_addr_in == 8'h26) && !phy_reset_in) |=> assess_irq_out)
    else $error("assessment interrupt dropped uncleared");
  c_irq: cover property ($rose(assess_irq_out));
  c_full: cover property ($fell(rx_data_ready_out));
  c_antenna: cover property ($rose(antenna_sel_out));
endmodule
bind rx_assess_ctrl rx_assess_monitor #(.DEPTH_LOG2(DEPTH_LOG2), .ED_PERIOD(ED_PERIOD)) u_monitor (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
  .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
  .reg_rvalid_out(reg_rvalid_out), .rx_on_cmd_in(rx_on_cmd_in), .transceiver_off_command_cmd_in(transceiver_off_command_cmd_in),
  .phy_reset_in(phy_reset_in), .rx_data_ready_out(rx_data_ready_out), .rx_bank_done_out(rx_bank_done_out),
  .receiving_out(receiving_out), .antenna_sel_out(antenna_sel_out), .assess_irq_out(assess_irq_out)
);

/* tb/rx_front_model.sv */
// radio front end model: energy per antenna and a byte source that holds until taken
module rx_front_model (
  // clock and reset
  input  wire        ref_clk_in,
  input  wire        rst_n_in,
  // control from the bench
  input  wire  [7:0] level_main_in,
  input  wire  [7:0] level_alt_in,
  input  wire        send_in,
  input  wire  [7:0] byte_in,
  // block side
  input  wire        antenna_sel_in,
  input  wire        ready_in,
  output wire  [7:0] energy_out,
  output logic       valid_out,
  output logic [7:0] data_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // energy follows whichever antenna the block has switched in
  assign energy_out = antenna_sel_in ? level_alt_in : level_main_in;
  always @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      valid_out <= 1'b0;
      data_out  <= 8'h00;
    end else if (send_in) begin
      valid_out <= 1'b1;
      data_out  <= byte_in;
    end else if (valid_out && ready_in) begin
      valid_out <= 1'b0;
      // released data no longer shows the last byte
      data_out  <= ~data_out;
    end
  end
endmodule

/* tb/rx_assess_ctrl_tb.sv */
// self-checking bench for the receive assessment block
module rx_assess_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk_in = 1'b0;
  logic       rst_n_in = 1'b0;
  logic       reg_wr_in = 1'b0;
  logic       reg_rd_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [7:0] reg_wdata_in = 8'h00;
  logic [2:0] cmd = 3'h0;
  logic       preamble = 1'b0;
  logic       sfd = 1'b0;
  logic       send = 1'b0;
  logic [7:0] send_byte = 8'h00;
  logic [7:0] lvl_main = 8'h00;
  logic [7:0] lvl_alt = 8'h00;
  wire  [7:0] energy, rx_data, rdata;
  wire        valid, ready, rvalid, bank_done, receiving, irq, ant, bw_hold;
  int         mismatches = 0;
  int         total_checks = 0;
  logic [7:0] d, p;
  always #5 ref_clk_in = ~ref_clk_in;
  rx_assess_ctrl #(.ED_PERIOD(20)) uut (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
    .rx_on_cmd_in(cmd[0]), .transceiver_off_command_cmd_in(cmd[1]), .phy_reset_in(cmd[2]), .energy_sample_in(energy),
    .preamble_det_in(preamble), .sfd_det_in(sfd), .filtered_drop_in(1'b0), .rx_data_valid_in(valid),
    .rx_data_in(rx_data), .rx_data_ready_out(ready), .rx_bank_done_out(bank_done), .receiving_out(receiving),
    .antenna_sel_out(ant), .bandwidth_hold_out(bw_hold), .assess_irq_out(irq));
  rx_front_model u_front (
    .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .level_main_in(lvl_main), .level_alt_in(lvl_alt),
    .send_in(send), .byte_in(send_byte), .antenna_sel_in(ant), .ready_in(ready), .energy_out(energy),
    .valid_out(valid), .data_out(rx_data));
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", n, e, g);
      mismatches++;
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b1;
    reg_addr_in <= a;
    reg_wdata_in <= v;
    @(posedge ref_clk_in);
    reg_wr_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b1;
    reg_addr_in <= a;
    @(posedge ref_clk_in);
    reg_rd_in <= 1'b0;
    #1;
    v = (rvalid === 1'b1) ? rdata : 8'hxx;
  endtask
  task automatic rchk(input string n, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    rd(a, d);
    chk(n, e, d & m);
  endtask
  task automatic poll(input string n, input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
                      input int lim);
    for (int i = 0; i < lim; i++) begin
      rd(a, d);
      if ((d & m) === e) break;
    end
    chk(n, e, d & m);
  endtask
  task automatic pulse(input logic [2:0] c);
    @(posedge ref_clk_in);
    cmd <= c;
    @(posedge ref_clk_in);
    cmd <= 3'h0;
  endtask
  task automatic push(input logic [7:0] b, input bit wait_taken);
    @(posedge ref_clk_in);
    send <= 1'b1;
    send_byte <= b;
    @(posedge ref_clk_in);
    send <= 1'b0;
    #1;
    for (int i = 0; i < 20 && wait_taken && valid; i++) @(posedge ref_clk_in);
    repeat (3) @(posedge ref_clk_in);
  endtask
  task automatic results;
    if (mismatches == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge ref_clk_in);
    mismatches++;
    results;
  end
  initial begin
    repeat (8) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rchk("threshold reset", 8'h13, 8'hff, 8'h50);
    rchk("search timer reset", 8'h6f, 8'hff, 8'h10);
    rchk("control reset", 8'h15, 8'hff, 8'h00);
    rchk("unmapped read", 8'h30, 8'hff, 8'h00);
    wr(8'h13, 8'h40);
    rchk("threshold write", 8'h13, 8'hff, 8'h40);
    // fill the buffer until it refuses, then drain it
    pulse(3'h1);
    push(8'ha5, 1'b1);
    push(8'h3c, 1'b1);
    push(8'h77, 1'b0);
    chk("ready when full", 8'h00, {7'h0, ready});
    chk("source stalled", 8'h01, {7'h0, valid});
    rchk("first byte", 8'h7f, 8'hff, 8'ha5);
    repeat (4) @(posedge ref_clk_in);
    rchk("second byte", 8'h7f, 8'hff, 8'h3c);
    rchk("third byte", 8'h7f, 8'hff, 8'h77);
    rchk("dummy byte", 8'h7f, 8'hff, 8'h00);
    chk("buffer empty", 8'h01, {7'h0, bank_done});
    push(8'h11, 1'b1);
    push(8'h22, 1'b1);
    wr(8'h24, 8'h3f);
    repeat (2) @(posedge ref_clk_in);
    chk("bank clear", 8'h01, {7'h0, bank_done});
    rchk("cleared read", 8'h7f, 8'hff, 8'h00);
    push(8'h33, 1'b1);
    pulse(3'h4);
    repeat (2) @(posedge ref_clk_in);
    chk("phy reset empties", 8'h01, {7'h0, bank_done});
    // single assessment armed before receive, busy channel
    pulse(3'h2);
    lvl_main <= 8'h60;
    wr(8'h1b, 8'h80);
    rchk("energy calc enable", 8'h1b, 8'h80, 8'h80);
    wr(8'h15, 8'h10);
    pulse(3'h1);
    poll("single busy", 8'h15, 8'hff, 8'h05, 20);
    repeat (2) @(posedge ref_clk_in);
    chk("receiving kept", 8'h01, {7'h0, receiving});
    chk("irq raised", 8'h01, {7'h0, irq});
    wr(8'h26, 8'h00);
    lvl_main <= 8'h10;
    repeat (3) @(posedge ref_clk_in);
    chk("irq cleared", 8'h00, {7'h0, irq});
    // enable while receiving waits for the filter to settle
    wr(8'h15, 8'h10);
    repeat (1500) @(posedge ref_clk_in);
    chk("settling wait", 8'h00, {7'h0, irq});
    poll("single idle", 8'h26, 8'h02, 8'h02, 200);
    rchk("idle result", 8'h15, 8'h13, 8'h00);
    // continuous assessment, then stop
    wr(8'h26, 8'h00);
    pulse(3'h2);
    lvl_main <= 8'h60;
    wr(8'h15, 8'h18);
    pulse(3'h1);
    repeat (100) @(posedge ref_clk_in);
    chk("loop irq", 8'h00, {7'h0, irq});
    rchk("loop busy", 8'h15, 8'h07, 8'h01);
    rd(8'h19, p);
    @(posedge ref_clk_in);
    lvl_main <= 8'h10;
    sfd <= 1'b1;
    repeat (60) @(posedge ref_clk_in);
    rchk("loop follows", 8'h15, 8'h03, 8'h00);
    rd(8'h19, d);
    chk("progress moves", 8'h01, {7'h0, d !== p});
    chk("bandwidth hold", 8'h01, {7'h0, bw_hold});
    wr(8'h15, 8'h38);
    lvl_main <= 8'h60;
    rd(8'h19, p);
    repeat (60) @(posedge ref_clk_in);
    rchk("frozen result", 8'h15, 8'h03, 8'h00);
    rchk("frozen progress", 8'h19, 8'hff, p);
    // two-antenna diversity, then wipe by interrupt clear
    pulse(3'h2);
    wr(8'h15, 8'h00);
    wr(8'h26, 8'h00);
    lvl_main <= 8'h20;
    lvl_alt <= 8'h70;
    preamble <= 1'b1;
    wr(8'h71, 8'h02);
    pulse(3'h1);
    poll("diversity done", 8'h26, 8'h01, 8'h01, 2000);
    rchk("chosen antenna", 8'h73, 8'hff, 8'h01);
    rchk("diversity energy", 8'h72, 8'hff, 8'h70);
    wr(8'h26, 8'h00);
    rchk("antenna wiped", 8'h73, 8'hff, 8'h00);
    rchk("energy wiped", 8'h72, 8'hff, 8'h00);
    results;
  end
endmodule
